// ==== include/tsp_link_if.sv ====
// Serial control link between bus master and device
`timescale 1ns/1ps
interface tsp_link_if;

  // ----------------------------------------------------------------
  // Link signals
  // ----------------------------------------------------------------
  logic sclk;
  logic csb_b;
  logic sdo;
  logic host_dio_out;
  logic host_dio_oe_b;
  logic dev_dio_out;
  logic dev_dio_oe_b;
  logic dio;

  // Resolved level of the shared data line, pulled high when neither end drives it
  assign dio = !host_dio_oe_b ? host_dio_out :
               (!dev_dio_oe_b ? dev_dio_out : 1'b1);

  modport dev (
    input  sclk,
    input  csb_b,
    input  dio,
    output sdo,
    output dev_dio_out,
    output dev_dio_oe_b
  );

  modport host (
    output sclk,
    output csb_b,
    output host_dio_out,
    output host_dio_oe_b,
    input  dio,
    input  sdo
  );

endinterface

// ==== include/tsp_pkg.sv ====
// Shared constants and types for the transceiver serial control port
package tsp_pkg;

  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 4;
  localparam int SCLK_HALF_NS = 24;
  localparam int HALF_CYC     = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W        = 4;
  localparam logic [TMR_W-1:0] HALF_LAST = TMR_W'(HALF_CYC - 1);

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS   = 16;
  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 8;
  localparam int CNT_W      = 5;
  localparam int DIR_POS    = 23;
  localparam int ADDR_POS   = 8;
  localparam logic [CNT_W-1:0] CNT_HDR  = CNT_W'(HDR_BITS);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAME_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_END  = CNT_W'(FRAME_BITS);
  localparam logic [CNT_W-1:0] CNT_HDR_LAST = CNT_W'(HDR_BITS - 1);
  localparam logic DIR_READ  = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  // ----------------------------------------------------------------
  // Device register store
  // ----------------------------------------------------------------
  localparam int REG_DEPTH = 16;
  localparam int REG_IDX_W = 4;
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [DATA_W-1:0] RD_MISS = 8'h00;

  // ----------------------------------------------------------------
  // Master sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_LOW  = 3'b001,
    HS_HIGH = 3'b011,
    HS_TAIL = 3'b010,
    HS_GAP  = 3'b110
  } tsp_hstate_t;

endpackage

// ==== verif/testbench.sv ====
// Bench joining host and device ends of the serial control port
`timescale 1ns/1ps
module testbench;
  import tsp_pkg::*;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic              mclk  = 1'b0;
  logic              rst_b = 1'b0;
  logic              req   = 1'b0;
  logic              rd    = 1'b0;
  logic              m3    = 1'b0;
  logic [ADDR_W-1:0] addr  = '0;
  logic [DATA_W-1:0] wdat  = '0;
  logic              busy, done, wr_stb, rd_stb, ferr, ferr2, wstb2, fact;
  logic [DATA_W-1:0] rdata, wr_data, exp_rd, d;
  logic [ADDR_W-1:0] wr_addr, rd_addr, a;
  logic [DATA_W-1:0] mem [16];
  logic [24:0]       notes[$];
  int                error_cnt = 0;
  int                total_checks = 0;
  int                n;

  tsp_link_if lnk ();
  tsp_link_if lnk2 ();
  tsp_host i_tsp_host (.mclk_i(mclk), .rst_b_i(rst_b), .link(lnk.host), .req_i(req),
    .req_read_i(rd), .req_addr_i(addr), .req_wdata_i(wdat), .mode_3wire_i(m3),
    .busy_o(busy), .done_o(done), .rdata_o(rdata));
  tsp_dev i_tsp_dev (.mclk_i(mclk), .rst_b_i(rst_b), .link(lnk.dev), .mode_3wire_i(m3),
    .wr_stb_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_stb_o(rd_stb),
    .rd_addr_o(rd_addr), .frame_err_o(ferr), .frame_act_o(fact));
  tsp_dev i_tsp_dev_flt (.mclk_i(mclk), .rst_b_i(rst_b), .link(lnk2.dev),
    .mode_3wire_i(1'b0), .wr_stb_o(wstb2), .wr_addr_o(), .wr_data_o(), .rd_stb_o(),
    .rd_addr_o(), .frame_err_o(ferr2), .frame_act_o());
  tsp_link_sva i_tsp_link_sva (.mclk_i(mclk), .rst_b_i(rst_b), .sclk(lnk.sclk),
    .csb_b(lnk.csb_b), .sdo(lnk.sdo), .host_dio_out(lnk.host_dio_out),
    .host_dio_oe_b(lnk.host_dio_oe_b), .dev_dio_out(lnk.dev_dio_out),
    .dev_dio_oe_b(lnk.dev_dio_oe_b), .dio(lnk.dio));

  always #2 mclk = ~mclk;

  task automatic chk(input string nm, input logic [24:0] seen, input logic [24:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic take(input string nm, input logic [24:0] seen);
    if (notes.size() == 0) chk(nm, seen, 25'h1FFFFFF);
    else chk(nm, seen, notes.pop_front());
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Host request; notes what the device and host must report
  task automatic xfer(input logic r, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt);
    if (ad < 15'h0010) begin
      notes.push_back(r ? {2'h1, ad, 8'h00} : {2'h0, ad, dt});
      if (r) exp_rd = mem[ad[3:0]];
      else mem[ad[3:0]] = dt;
    end else if (r) exp_rd = RD_MISS;
    notes.push_back({2'h2, 15'h0000, exp_rd});
    req <= 1'b1;
    rd <= r;
    addr <= ad;
    wdat <= dt;
    @(posedge mclk);
    req <= 1'b0;
    @(posedge mclk);
    chk("busy in frame", 25'(busy), 25'h1);
    repeat (20) @(posedge mclk);
    chk("frame active", 25'(fact), 25'h1);
    n = 21;
    while (done !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    chk("answer in time", 25'(n < 400), 25'h1);
    repeat (8) @(posedge mclk);
    chk("frame idle", 25'({busy, fact}), 25'h0);
  endtask

  // Results leave the queue oldest first
  always @(posedge mclk) begin
    if (wr_stb === 1'b1 && wr_addr < 15'h0010)
      take("write", {2'h0, wr_addr, wr_data});
    if (rd_stb === 1'b1 && rd_addr < 15'h0010)
      take("read load", {2'h1, rd_addr, 8'h00});
    if (done === 1'b1)
      take("done", {2'h2, 15'h0000, rdata});
    if (ferr === 1'b1 || wstb2 === 1'b1)
      chk("stray strobe", 25'h1, 25'h0);
  end

  initial begin
    #100000;
    error_cnt++;
    summarize();
  end

  initial begin
    exp_rd = REG_RST;
    foreach (mem[i]) mem[i] = REG_RST;
    lnk2.sclk <= 1'b0;
    lnk2.csb_b <= 1'b1;
    lnk2.host_dio_out <= 1'b0;
    lnk2.host_dio_oe_b <= 1'b0;
    void'($urandom(48822));
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    for (int m = 0; m < 2; m++) begin
      m3 <= m[0];
      repeat (8) @(posedge mclk);
      xfer(1'b1, 15'h0007, 8'h00);
      for (int i = 0; i < 6; i++) begin
        a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h000F : 15'($urandom_range(15));
        d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
        xfer(1'b0, a, d);
        xfer(1'b1, a, 8'($urandom));
      end
      $display("test loopback mode %0d done", m);
    end
    fork
      xfer(1'b0, 15'h0009, 8'h11);
      begin
        repeat (50) @(posedge mclk);
        req <= 1'b1;
        @(posedge mclk);
        req <= 1'b0;
      end
    join
    xfer(1'b1, 15'h0009, 8'h00);
    xfer(1'b0, 15'h7FF5, 8'h3C);
    xfer(1'b1, 15'h0005, 8'h00);
    xfer(1'b1, 15'h7FFF, 8'h00);
    $display("test refused and out of range done");
    for (int b = 10; b < 24; b += 13) begin
      lnk2.csb_b <= 1'b0;
      repeat (b) begin
        repeat (6) @(posedge mclk);
        lnk2.sclk <= 1'b1;
        repeat (6) @(posedge mclk);
        lnk2.sclk <= 1'b0;
        lnk2.host_dio_out <= ~lnk2.host_dio_out;
      end
      repeat (6) @(posedge mclk);
      lnk2.csb_b <= 1'b1;
      lnk2.host_dio_out <= 1'b0;
      n = 0;
      while (ferr2 !== 1'b1 && n < 20) begin
        @(posedge mclk);
        n++;
      end
      chk("short frame flagged", 25'(n < 20), 25'h1);
      repeat (8) @(posedge mclk);
    end
    $display("test short frames done");
    chk("notes left", 25'(notes.size()), 25'h0);
    summarize();
  end
endmodule

// ==== verif/tsp_link_sva.sv ====
// Checker for the link between host and device ends
`timescale 1ns/1ps
module tsp_link_sva
  import tsp_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  // Link
  input  wire logic sclk,
  input  wire logic csb_b,
  input  wire logic sdo,
  input  wire logic host_dio_out,
  input  wire logic host_dio_oe_b,
  input  wire logic dev_dio_out,
  input  wire logic dev_dio_oe_b,
  input  wire logic dio
);
  logic             sclk_q;
  logic             dir_q;
  logic [CNT_W-1:0] cnt;
  wire              rise     = sclk && !sclk_q && !csb_b;
  wire [CNT_W-1:0]  next_cnt = csb_b ? '0 : cnt + CNT_W'(rise);
  wire              next_dir = (rise && cnt == '0) ? dio : dir_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_q <= 1'b0;
      dir_q  <= 1'b0;
      cnt    <= '0;
    end else begin
      sclk_q <= sclk;
      dir_q  <= next_dir;
      cnt    <= next_cnt;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_high;
    sclk [*6] ##1 !sclk;
  endsequence
  sequence s_gap;
    csb_b [*3];
  endsequence

  AST_NO_CLASH: assert property (host_dio_oe_b || dev_dio_oe_b)
    else $error("Shared line driven twice");
  AST_SCLK_IDLE: assert property (csb_b |-> !sclk)
    else $error("Clock moves outside frame");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> s_high)
    else $error("Clock high phase wrong");
  AST_FRAME_LEN: assert property ($rose(csb_b) |-> cnt == CNT_END ##0 s_gap)
    else $error("Frame not 24 bits");
  AST_HOST_HDR: assert property (!csb_b && cnt < CNT_HDR |-> !host_dio_oe_b)
    else $error("Header not driven by host");
  AST_HOST_REL: assert property ($rose(host_dio_oe_b) |-> cnt == CNT_HDR && dir_q)
    else $error("Host released line early");
  AST_DEV_DRV: assert property ($fell(dev_dio_oe_b) |-> cnt == CNT_HDR && dir_q)
    else $error("Device drove line wrongly");
  AST_DEV_REL: assert property ($rose(dev_dio_oe_b) |-> cnt == CNT_END)
    else $error("Device released line wrongly");
  AST_DIO_HOLD: assert property (sclk && sclk_q && !csb_b |-> $stable(dio))
    else $error("Data moved while clock high");
  AST_SDO_HDR: assert property (!csb_b && cnt < CNT_HDR |-> !sdo)
    else $error("Output line busy in header");
endmodule

// ==== verilog/tsp_dev.sv ====
// Device end of the serial control port with its byte register store
//
// Operation
// - Four-wire or three-wire data wiring supported.
// - Every transaction spans exactly 24 bit periods.
// - First bit gives direction, read or write.
// - Next fifteen bits select the target register.
// - Write stores last eight bits in register.
// - Master sends sixteen header bits on shared line.
// - Read returns byte in last eight periods.
`timescale 1ns/1ps
module tsp_dev
  import tsp_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_b_i,
  // Link
  tsp_link_if.dev                 link,
  // Wiring strap
  input  wire logic               mode_3wire_i,
  // Register write event
  output logic                    wr_stb_o,
  output logic [ADDR_W-1:0]       wr_addr_o,
  output logic [DATA_W-1:0]       wr_data_o,
  // Register read event
  output logic                    rd_stb_o,
  output logic [ADDR_W-1:0]       rd_addr_o,
  // Frame status
  output logic                    frame_err_o,
  output logic                    frame_act_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a < ADDR_W'(REG_DEPTH));
  endfunction

  function automatic logic [REG_IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] a);
    addr_idx = a[REG_IDX_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic sclk_m, sclk_s, sclk_d;
  logic csb_m, csb_s, csb_d;
  logic dio_m, dio_s;
  logic mode_m, mode_s;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      csb_m  <= 1'b1;
      csb_s  <= 1'b1;
      csb_d  <= 1'b1;
      dio_m  <= 1'b1;
      dio_s  <= 1'b1;
      mode_m <= 1'b0;
      mode_s <= 1'b0;
    end else begin
      sclk_m <= link.sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      csb_m  <= link.csb_b;
      csb_s  <= csb_m;
      csb_d  <= csb_s;
      dio_m  <= link.dio;
      dio_s  <= dio_m;
      mode_m <= mode_3wire_i;
      mode_s <= mode_m;
    end
  end

  // ----------------------------------------------------------------
  // Edge and frame decode
  // ----------------------------------------------------------------
  logic [CNT_W-1:0]     bit_cnt;
  logic [HDR_BITS-1:0]  hdr;
  logic [DATA_W-1:0]    wbyte;
  logic [DATA_W-1:0]    rshift;
  logic                 out_act;
  logic                 tx_bit;
  logic                 dio_oe_b;
  logic [DATA_W-1:0]    regs [REG_DEPTH];

  wire sel        = ~csb_s;
  wire sclk_rise  = sel & sclk_s & ~sclk_d;
  wire sclk_fall  = sel & ~sclk_s & sclk_d;
  wire csb_rise   = csb_s & ~csb_d;
  // Header and write data always arrive on the shared line
  wire in_bit     = dio_s;
  wire in_hdr     = (bit_cnt < CNT_HDR);
  wire is_read    = (hdr[HDR_BITS-1] == DIR_READ);
  wire [ADDR_W-1:0] addr = hdr[ADDR_W-1:0];
  wire [DATA_W-1:0] wr_val = {wbyte[DATA_W-2:0], in_bit};
  wire [DATA_W-1:0] rd_val = addr_hit(addr) ? regs[addr_idx(addr)] : RD_MISS;

  wire take_bit   = sclk_rise & (bit_cnt < CNT_END);
  wire wr_commit  = sclk_rise & ~is_read & (bit_cnt == CNT_LAST);
  wire rd_load    = sclk_fall & is_read & (bit_cnt == CNT_HDR) & ~out_act;
  wire rd_shift   = sclk_fall & out_act & (bit_cnt < CNT_END);
  wire rd_release = sclk_fall & out_act & (bit_cnt == CNT_END);
  wire bad_frame  = csb_rise & (bit_cnt != '0) & (bit_cnt != CNT_END);

  // ----------------------------------------------------------------
  // Bit counter and input shifting
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt <= '0;
      hdr     <= '0;
      wbyte   <= '0;
    end else if (!sel) begin
      bit_cnt <= '0;
    end else if (take_bit) begin
      bit_cnt <= bit_cnt + 1'b1;
      if (in_hdr) begin
        hdr <= {hdr[HDR_BITS-2:0], in_bit};
      end else begin
        wbyte <= wr_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register store
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs[i] <= REG_RST;
      end
    end else if (wr_commit && addr_hit(addr)) begin
      regs[addr_idx(addr)] <= wr_val;
    end
  end

  // ----------------------------------------------------------------
  // Read data return
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rshift   <= '0;
      tx_bit   <= 1'b0;
      out_act  <= 1'b0;
      dio_oe_b <= 1'b1;
    end else if (!sel || rd_release) begin
      out_act  <= 1'b0;
      tx_bit   <= 1'b0;
      dio_oe_b <= 1'b1;
    end else if (rd_load) begin
      rshift   <= {rd_val[DATA_W-2:0], 1'b0};
      tx_bit   <= rd_val[DATA_W-1];
      out_act  <= 1'b1;
      dio_oe_b <= ~mode_s;
    end else if (rd_shift) begin
      rshift <= {rshift[DATA_W-2:0], 1'b0};
      tx_bit <= rshift[DATA_W-1];
    end
  end

  // ----------------------------------------------------------------
  // User-side events
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_stb_o    <= 1'b0;
      wr_addr_o   <= '0;
      wr_data_o   <= '0;
      rd_stb_o    <= 1'b0;
      rd_addr_o   <= '0;
      frame_err_o <= 1'b0;
      frame_act_o <= 1'b0;
    end else begin
      wr_stb_o    <= wr_commit;
      rd_stb_o    <= rd_load;
      frame_err_o <= bad_frame;
      frame_act_o <= sel;
      if (wr_commit) begin
        wr_addr_o <= addr;
        wr_data_o <= wr_val;
      end
      if (rd_load) begin
        rd_addr_o <= addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  // Dedicated output carries the byte in both wirings; the shared line carries it in three-wire only
  assign link.sdo          = tx_bit;
  assign link.dev_dio_out  = tx_bit;
  assign link.dev_dio_oe_b = dio_oe_b;

endmodule

// ==== verilog/tsp_host.sv ====
// Bus master end of the serial control port
`timescale 1ns/1ps
module tsp_host
  import tsp_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk_i,
  input  wire logic               rst_b_i,
  // Link
  tsp_link_if.host                link,
  // Request
  input  wire logic               req_i,
  input  wire logic               req_read_i,
  input  wire logic [ADDR_W-1:0]  req_addr_i,
  input  wire logic [DATA_W-1:0]  req_wdata_i,
  input  wire logic               mode_3wire_i,
  // Answer
  output logic                    busy_o,
  output logic                    done_o,
  output logic [DATA_W-1:0]       rdata_o
);

  tsp_hstate_t            state;
  logic [TMR_W-1:0]       tmr;
  logic [CNT_W-1:0]       bit_cnt;
  logic [FRAME_BITS-1:0]  tx_shift;
  logic [DATA_W-1:0]      rx_shift;
  logic                   is_rd;
  logic                   mode3;
  logic                   sclk;
  logic                   csb_b;
  logic                   dio_out;
  logic                   dio_oe_b;
  logic                   sdo_m, sdo_s, dio_m, dio_s;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sdo_m <= 1'b0;
      sdo_s <= 1'b0;
      dio_m <= 1'b1;
      dio_s <= 1'b1;
    end else begin
      sdo_m <= link.sdo;
      sdo_s <= sdo_m;
      dio_m <= link.dio;
      dio_s <= dio_m;
    end
  end

  wire tmr_done = (tmr == HALF_LAST);
  wire rd_bit   = mode3 ? dio_s : sdo_s;
  wire rd_phase = is_rd && (bit_cnt >= CNT_HDR);
  wire [FRAME_BITS-1:0] frame = {req_read_i, req_addr_i, req_wdata_i};

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state    <= HS_IDLE;
      tmr      <= '0;
      bit_cnt  <= '0;
      tx_shift <= '0;
      rx_shift <= '0;
      is_rd    <= 1'b0;
      mode3    <= 1'b0;
      sclk     <= 1'b0;
      csb_b    <= 1'b1;
      dio_out  <= 1'b0;
      dio_oe_b <= 1'b0;
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      rdata_o  <= '0;
    end else begin
      done_o <= 1'b0;
      tmr    <= tmr_done ? '0 : tmr + 1'b1;
      unique case (state)
        HS_IDLE: begin
          tmr <= '0;
          if (req_i) begin
            tx_shift <= frame;
            dio_out  <= frame[DIR_POS];
            dio_oe_b <= 1'b0;
            is_rd    <= req_read_i;
            mode3    <= mode_3wire_i;
            bit_cnt  <= '0;
            csb_b    <= 1'b0;
            busy_o   <= 1'b1;
            state    <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tmr_done) begin
            sclk  <= 1'b1;
            state <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (tmr_done) begin
            sclk <= 1'b0;
            if (rd_phase) begin
              rx_shift <= {rx_shift[DATA_W-2:0], rd_bit};
            end
            if (bit_cnt == CNT_LAST) begin
              state <= HS_TAIL;
            end else begin
              bit_cnt  <= bit_cnt + 1'b1;
              tx_shift <= {tx_shift[FRAME_BITS-2:0], 1'b0};
              dio_out  <= tx_shift[FRAME_BITS-2];
              if (is_rd && mode3 && bit_cnt == CNT_HDR_LAST) begin
                dio_oe_b <= 1'b1;
              end
              state <= HS_LOW;
            end
          end
        end
        HS_TAIL: begin
          if (tmr_done) begin
            csb_b  <= 1'b1;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            if (is_rd) begin
              rdata_o <= rx_shift;
            end
            state <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (tmr_done) begin
            dio_out  <= 1'b0;
            dio_oe_b <= 1'b0;
            state    <= HS_IDLE;
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.sclk          = sclk;
  assign link.csb_b         = csb_b;
  assign link.host_dio_out  = dio_out;
  assign link.host_dio_oe_b = dio_oe_b;

endmodule
